// ### blx_core.sv
// Purpose: Executes AND, bit clear/set, bit test with skip, call, clears and watchdog kick.
// Assumes: Software writes one instruction word at a time over APB; pclk is 40 MHz.
// Notes: One instruction cycle is four pclk phases; the file memory sits in this module.
`timescale 1ns/1ps
`include "blx_regs.svh"

module blx_core (
  // Clock, reset and freeze.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire blx_pkg::blx_apb_req_s apb_req,
  output blx_pkg::blx_apb_rsp_s apb_rsp,
  // Execution status.
  output logic exec_busy
);

  // Sorts an instruction word into its class; used in several phases.
  function automatic blx_pkg::blx_op_e blx_decode(input logic [13:0] w);
    blx_pkg::blx_op_e op;
    op = blx_pkg::OP_OTHER;
    if (w[13:8] == `BLX_PAT_AND) begin
      op = blx_pkg::OP_AND;
    end else if (w[13:12] == `BLX_PAT_BIT) begin
      unique case (w[11:10])
        `BLX_BIT_CLEAR: op = blx_pkg::OP_BIT_CLEAR;
        `BLX_BIT_SET: op = blx_pkg::OP_BIT_SET;
        `BLX_BIT_TSC: op = blx_pkg::OP_TEST_CLEAR;
        `BLX_BIT_TSS: op = blx_pkg::OP_TEST_SET;
      endcase
    end else if (w[13:11] == `BLX_PAT_CALL) begin
      op = blx_pkg::OP_CALL;
    end else if (w[13:7] == `BLX_PAT_ZFILE) begin
      op = blx_pkg::OP_ZERO_FILE;
    // Low seven bits are don't care.
    end else if (w[13:7] == `BLX_PAT_ZACC) begin
      op = blx_pkg::OP_ZERO_ACC;
    end else if (w == `BLX_PAT_KICK) begin
      op = blx_pkg::OP_KICK;
    end
    return op;
  endfunction

  // Mask selecting one bit of a file register.
  function automatic logic [7:0] blx_bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  blx_pkg::blx_state_s s_q;
  blx_pkg::blx_state_s s_d;
  logic [7:0] file_q [128];
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  logic [7:0] exec_rdata;
  logic [7:0] apb_rdata;
  blx_pkg::blx_op_e op;
  logic [2:0] bsel;
  logic access;
  logic done;
  logic refused;
  logic [7:0] st_word;
  logic [2:0] sp_top;

  // Seven-bit file address and three-bit bit select.
  assign exec_rdata = file_q[s_q.ir[6:0]];
  assign bsel = s_q.ir[9:7];
  assign apb_rdata = file_q[s_q.faddr];
  assign op = blx_decode(s_q.ir);
  assign access = apb_req.psel & apb_req.penable;
  assign done = access & s_q.rsp.pready;
  assign sp_top = s_q.sp - 3'h1;

  // Status word as software sees it.
  always_comb begin
    st_word = 8'h00;
    st_word[`BLX_ST_ZERO] = s_q.zero;
    st_word[`BLX_ST_POWER_DOWN_N] = s_q.power_down_n;
    st_word[`BLX_ST_EXPIRY_N] = s_q.expiry_n;
    st_word[`BLX_ST_BUSY] = s_q.busy;
    st_word[`BLX_ST_NOP_CYCLE] = s_q.in_nop;
  end

  // Writes that would race the running instruction are refused while it is busy.
  always_comb begin
    refused = 1'b0;
    if (apb_req.pwrite && s_q.busy) begin
      unique case (apb_req.paddr)
        `BLX_OFF_INSTR, `BLX_OFF_ACC, `BLX_OFF_PC, `BLX_OFF_UPLATCH, `BLX_OFF_FILE_DATA: begin
          refused = 1'b1;
        end
        default: refused = 1'b0;
      endcase
    end
  end

  // Next state: APB slave, instruction phases and watchdog.
  always_comb begin
    s_d = s_q;
    file_we = 1'b0;
    file_waddr = s_q.ir[6:0];
    file_wdata = s_q.result;

    // Watchdog runs from pclk through its prescaler; wrap of both clears expiry_n.
    s_d.prescaler = s_q.prescaler + 8'h01;
    if (s_q.prescaler == 8'hff) begin
      s_d.watchdog = s_q.watchdog + 8'h01;
      if (s_q.watchdog == 8'hff) begin
        s_d.expiry_n = 1'b0;
      end
    end

    // APB: ready one cycle into the access phase, read data and error captured with it.
    s_d.rsp.pready = access & ~s_q.rsp.pready;
    if (access && !s_q.rsp.pready) begin
      s_d.rsp.pslverr = refused;
      s_d.rsp.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        `BLX_OFF_INSTR: s_d.rsp.prdata = {18'h00000, s_q.ir};
        `BLX_OFF_STATUS: s_d.rsp.prdata = {24'h000000, st_word};
        `BLX_OFF_ACC: s_d.rsp.prdata = {24'h000000, s_q.acc};
        `BLX_OFF_PC: s_d.rsp.prdata = {19'h00000, s_q.pc};
        `BLX_OFF_UPLATCH: s_d.rsp.prdata = {27'h0000000, s_q.uplatch};
        `BLX_OFF_STACK_TOP: s_d.rsp.prdata = {16'h0000, s_q.sp, s_q.stack[sp_top]};
        `BLX_OFF_FILE_ADDR: s_d.rsp.prdata = {25'h0000000, s_q.faddr};
        `BLX_OFF_FILE_DATA: s_d.rsp.prdata = {24'h000000, apb_rdata};
        `BLX_OFF_WATCHDOG: s_d.rsp.prdata = {16'h0000, s_q.prescaler, s_q.watchdog};
        default: s_d.rsp.pslverr = 1'b1;
      endcase
    end else if (!access) begin
      s_d.rsp.pslverr = 1'b0;
    end

    // Writes take effect only at the completing edge and only if not refused.
    if (done && apb_req.pwrite && !s_q.rsp.pslverr) begin
      unique case (apb_req.paddr)
        `BLX_OFF_INSTR: begin
          s_d.ir = apb_req.pwdata[13:0];
          s_d.busy = 1'b1;
          s_d.phase = blx_pkg::PH_DECODE;
          s_d.extra = 1'b0;
          s_d.in_nop = 1'b0;
          s_d.skip = 1'b0;
        end
        `BLX_OFF_ACC: s_d.acc = apb_req.pwdata[7:0];
        `BLX_OFF_PC: s_d.pc = apb_req.pwdata[12:0];
        `BLX_OFF_UPLATCH: s_d.uplatch = apb_req.pwdata[4:0];
        `BLX_OFF_FILE_ADDR: s_d.faddr = apb_req.pwdata[6:0];
        `BLX_OFF_FILE_DATA: begin
          file_we = 1'b1;
          file_waddr = s_q.faddr;
          file_wdata = apb_req.pwdata[7:0];
        end
        default: s_d.rsp.pslverr = 1'b0;
      endcase
    end

    if (s_q.busy) begin
      s_d.phase = blx_pkg::blx_phase_e'(s_q.phase + 2'b01);
      if (!s_q.in_nop) begin
        unique case (s_q.phase)
          blx_pkg::PH_DECODE: s_d.operand = 8'h00;
          blx_pkg::PH_READ: begin
            s_d.operand = exec_rdata;
            if (op == blx_pkg::OP_CALL) begin
              s_d.stack[s_q.sp] = s_q.pc + 13'h0001;
              s_d.sp = s_q.sp + 3'h1;
            end
          end
          blx_pkg::PH_PROCESS: begin
            unique case (op)
              blx_pkg::OP_AND: s_d.result = s_q.acc & s_q.operand;
              blx_pkg::OP_BIT_CLEAR: s_d.result = s_q.operand & ~blx_bit_mask(bsel);
              blx_pkg::OP_BIT_SET: s_d.result = s_q.operand | blx_bit_mask(bsel);
              blx_pkg::OP_TEST_CLEAR: s_d.skip = ~s_q.operand[bsel];
              blx_pkg::OP_TEST_SET: s_d.skip = s_q.operand[bsel];
              default: s_d.result = 8'h00;
            endcase
          end
          blx_pkg::PH_WRITE: begin
            s_d.pc = s_q.pc + 13'h0001;
            s_d.extra = s_q.skip;
            unique case (op)
              blx_pkg::OP_AND: begin
                if (s_q.ir[7]) begin
                  file_we = 1'b1;
                end else begin
                  s_d.acc = s_q.result;
                end
                s_d.zero = (s_q.result == 8'h00);
              end
              blx_pkg::OP_BIT_CLEAR, blx_pkg::OP_BIT_SET: file_we = 1'b1;
              blx_pkg::OP_CALL: begin
                s_d.pc = {s_q.uplatch[4:3], s_q.ir[10:0]};
                s_d.extra = 1'b1;
              end
              blx_pkg::OP_ZERO_FILE: begin
                file_we = 1'b1;
                s_d.zero = 1'b1;
              end
              blx_pkg::OP_ZERO_ACC: begin
                s_d.acc = 8'h00;
                s_d.zero = 1'b1;
              end
              blx_pkg::OP_KICK: begin
                s_d.watchdog = 8'h00;
                s_d.prescaler = 8'h00;
                s_d.expiry_n = 1'b1;
                s_d.power_down_n = 1'b1;
              end
              default: s_d.extra = s_q.skip;
            endcase
            if (s_d.extra) begin
              s_d.in_nop = 1'b1;
            end else begin
              s_d.busy = 1'b0;
            end
          end
        endcase
      end else if (s_q.phase == blx_pkg::PH_WRITE) begin
        // End of the NOP cycle; a skip steps past the discarded word.
        s_d.busy = 1'b0;
        s_d.in_nop = 1'b0;
        s_d.extra = 1'b0;
        s_d.skip = 1'b0;
        if (s_q.skip) begin
          s_d.pc = s_q.pc + 13'h0001;
        end
      end
    end
  end

  // State register; clk_en low freezes everything, including the APB answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.acc <= `BLX_RST_ACC;
      s_q.pc <= `BLX_RST_PC;
      s_q.uplatch <= `BLX_RST_UPLATCH;
      s_q.expiry_n <= `BLX_RST_FLAG_N;
      s_q.power_down_n <= `BLX_RST_FLAG_N;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // File memory has no reset; software must initialise what it reads.
  always_ff @(posedge pclk) begin
    if (clk_en && file_we) begin
      file_q[file_waddr] <= file_wdata;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign exec_busy = s_q.busy;

endmodule // blx_core

// ### blx_core_sva.sv
// Purpose: Port-level timing, flag and error checks of the bit/logic execution unit.
// Assumes: clk_en stays high while an instruction runs.
// Notes: Bound to blx_core after the module.
`timescale 1ns/1ps
`include "blx_regs.svh"
module blx_core_sva (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Bus and status.
  input wire blx_pkg::blx_apb_req_s apb_req,
  input wire blx_pkg::blx_apb_rsp_s apb_rsp,
  input wire logic exec_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [13:0] ir_q;
  logic [3:0] cnt_q;
  logic go;
  logic rd_st;
  // An accepted instruction write and an idle status read.
  assign go = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
    && apb_req.paddr == `BLX_OFF_INSTR && !exec_busy;
  assign rd_st = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == `BLX_OFF_STATUS
    && !exec_busy;
  // Keep the last accepted word; count busy cycles so run lengths can be judged at the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_q <= 14'h0000;
      cnt_q <= 4'h0;
    end else begin
      if (go) begin
        ir_q <= apb_req.pwdata[13:0];
      end
      cnt_q <= exec_busy ? cnt_q + 4'h1 : 4'h0;
    end
  end
  chk_ready_wait: assert property (apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
    else $error("pready late or missing");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  chk_busy_start: assert property (go |=> exec_busy)
    else $error("busy did not start");
  chk_busy_hold: assert property ($rose(exec_busy) |-> exec_busy[*4])
    else $error("instruction shorter than four phases");
  chk_call_len: assert property ($fell(exec_busy) && ir_q[13:11] == `BLX_PAT_CALL
    |-> cnt_q == 4'h8)
    else $error("call not two cycles");
  chk_single_len: assert property ($fell(exec_busy) && (ir_q[13:8] == `BLX_PAT_AND
    || (ir_q[13:12] == `BLX_PAT_BIT && !ir_q[11]) || ir_q[13:8] == 6'h01
    || ir_q == `BLX_PAT_KICK) |-> cnt_q == 4'h4)
    else $error("single-cycle op wrong length");
  chk_skip_len: assert property ($fell(exec_busy) && ir_q[13:12] == `BLX_PAT_BIT && ir_q[11]
    |-> cnt_q == 4'h4 || cnt_q == 4'h8)
    else $error("bit test wrong length");
  chk_zero_set: assert property (rd_st && ir_q[13:8] == 6'h01 |-> apb_rsp.prdata[0])
    else $error("zero flag not set by clear");
  chk_kick_flags: assert property (rd_st && ir_q == `BLX_PAT_KICK
    |-> apb_rsp.prdata[2:1] == 2'b11)
    else $error("kick left a flag low");
  chk_unmapped: assert property (apb_rsp.pready && apb_req.paddr > `BLX_OFF_WATCHDOG
    |-> apb_rsp.pslverr)
    else $error("unmapped access not refused");
endmodule // blx_core_sva

bind blx_core blx_core_sva blx_core_sva_inst (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp), .exec_busy(exec_busy));

// ### blx_pkg.sv
// Purpose: Types shared by the bit/logic execution unit and its bench.
// Assumes: Constants live in blx_regs.svh.
// Notes: Nothing here is imported; use blx_pkg::name.
package blx_pkg;

  // Instruction class after decode.
  typedef enum logic [3:0] {
    OP_OTHER = 4'h0,
    OP_AND = 4'h1,
    OP_BIT_CLEAR = 4'h2,
    OP_BIT_SET = 4'h3,
    OP_TEST_CLEAR = 4'h4,
    OP_TEST_SET = 4'h5,
    OP_CALL = 4'h6,
    OP_ZERO_FILE = 4'h7,
    OP_ZERO_ACC = 4'h8,
    OP_KICK = 4'h9
  } blx_op_e;

  // Oscillator phase within one instruction cycle.
  typedef enum logic [1:0] {
    PH_DECODE = 2'b00,
    PH_READ = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE = 2'b11
  } blx_phase_e;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } blx_apb_req_s;

  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } blx_apb_rsp_s;

  // Whole state of the core except the file memory.
  typedef struct packed {
    blx_phase_e phase;
    logic busy;
    logic extra;
    logic in_nop;
    logic skip;
    logic [13:0] ir;
    logic [7:0] operand;
    logic [7:0] result;
    logic [7:0] acc;
    logic zero;
    logic expiry_n;
    logic power_down_n;
    logic [12:0] pc;
    logic [4:0] uplatch;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    logic [6:0] faddr;
    logic [7:0] watchdog;
    logic [7:0] prescaler;
    blx_apb_rsp_s rsp;
  } blx_state_s;

endpackage

// ### blx_regs.svh
// Purpose: Offsets, field positions, opcode patterns and reset values of the bit/logic unit.
// Assumes: APB with 32-bit data; every register is one aligned word.
// Notes: Definitions only; included by the core.
`ifndef BLX_REGS_SVH
`define BLX_REGS_SVH

// Register byte addresses.
`define BLX_OFF_INSTR 8'h00
`define BLX_OFF_STATUS 8'h04
`define BLX_OFF_ACC 8'h08
`define BLX_OFF_PC 8'h0c
`define BLX_OFF_UPLATCH 8'h10
`define BLX_OFF_STACK_TOP 8'h14
`define BLX_OFF_FILE_ADDR 8'h18
`define BLX_OFF_FILE_DATA 8'h1c
`define BLX_OFF_WATCHDOG 8'h20

// Status register field positions.
`define BLX_ST_ZERO 0
`define BLX_ST_POWER_DOWN_N 1
`define BLX_ST_EXPIRY_N 2
`define BLX_ST_BUSY 3
`define BLX_ST_NOP_CYCLE 4

// Opcode patterns.
`define BLX_PAT_AND 6'h05
`define BLX_PAT_BIT 2'h1
`define BLX_BIT_CLEAR 2'h0
`define BLX_BIT_SET 2'h1
`define BLX_BIT_TSC 2'h2
`define BLX_BIT_TSS 2'h3
`define BLX_PAT_CALL 3'h4
`define BLX_PAT_ZFILE 7'h03
`define BLX_PAT_ZACC 7'h02
`define BLX_PAT_KICK 14'h0064

// Reset values.
`define BLX_RST_ACC 8'h00
`define BLX_RST_PC 13'h0000
`define BLX_RST_UPLATCH 5'h00
`define BLX_RST_FLAG_N 1'b1

// Timing: oscillator phases per instruction cycle and return stack depth.
`define BLX_PHASES 4
`define BLX_STACK_DEPTH 8

`endif

// ### tb.sv
// Purpose: Self-checking bench for the bit/logic execution unit.
// Assumes: 40 MHz pclk; registers reached over APB.
// Notes: Each scenario is a task that judges its own reads.
`timescale 1ns/1ps
`include "blx_regs.svh"
module tb;
  logic pclk;
  logic presetn;
  logic clk_en;
  blx_pkg::blx_apb_req_s req;
  blx_pkg::blx_apb_rsp_s rsp;
  logic exec_busy;
  logic [31:0] rdat;
  logic rerr;
  int checks;
  int bad_count;
  int cyc;
  blx_core blx_core_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .exec_busy(exec_busy));
  // Clock at 25 ns; the timeout cuts a hung handshake short.
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One APB transfer; pready is sampled at the rising edge, as the slave sees the request.
  // An idle edge follows the release so a second call never rewrites req in one time step.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    checks++;
    if ((rdat & m) !== e) begin
      bad_count++;
      $display("unexpected reg %h: expected %h seen %h", a, e, rdat & m);
    end
  endtask
  task automatic ec(input logic e);
    checks++;
    if (rerr !== e) begin
      bad_count++;
      $display("unexpected pslverr: expected %b seen %b", e, rerr);
    end
  endtask
  task automatic run(input logic [13:0] op);
    xfer(1'b1, `BLX_OFF_INSTR, {18'h0, op});
    do @(posedge pclk); while (exec_busy !== 1'b0);
    @(posedge pclk);
  endtask
  task automatic t_and();
    xfer(1'b1, `BLX_OFF_ACC, 32'h17);
    xfer(1'b1, `BLX_OFF_FILE_ADDR, 32'h7f);
    xfer(1'b1, `BLX_OFF_FILE_DATA, 32'hc2);
    run(14'h05ff);
    rc(`BLX_OFF_FILE_DATA, 32'hff, 32'h02);
    rc(`BLX_OFF_STATUS, 32'h1, 32'h0);
    xfer(1'b1, `BLX_OFF_ACC, 32'h3d);
    run(14'h057f);
    rc(`BLX_OFF_ACC, 32'hff, 32'h00);
    rc(`BLX_OFF_STATUS, 32'h1, 32'h1);
  endtask
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      xfer(1'b1, `BLX_OFF_FILE_DATA, 32'h00);
      run(14'h147f | 14'(b << 7));
      rc(`BLX_OFF_FILE_DATA, 32'hff, 32'h1 << b);
      xfer(1'b1, `BLX_OFF_FILE_DATA, 32'hff);
      run(14'h107f | 14'(b << 7));
      rc(`BLX_OFF_FILE_DATA, 32'hff, 32'hff ^ (32'h1 << b));
    end
    rc(`BLX_OFF_STATUS, 32'h1, 32'h1);
  endtask
  // Bit 1 set, bit 0 clear: test both polarities on both bits.
  task automatic t_skip();
    xfer(1'b1, `BLX_OFF_FILE_DATA, 32'h02);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `BLX_OFF_PC, 32'h10);
      run(14'h187f | 14'((i & 2) << 9) | 14'((i & 1) << 7));
      rc(`BLX_OFF_PC, 32'h1fff, (i == 0 || i == 3) ? 32'h12 : 32'h11);
    end
  endtask
  task automatic t_call();
    xfer(1'b1, `BLX_OFF_UPLATCH, 32'h17);
    xfer(1'b1, `BLX_OFF_PC, 32'h123);
    run(14'h27ff);
    rc(`BLX_OFF_PC, 32'h1fff, 32'h17ff);
    rc(`BLX_OFF_STACK_TOP, 32'hffff, 32'h2124);
    rc(`BLX_OFF_STATUS, 32'h1, 32'h1);
  endtask
  task automatic t_clear();
    xfer(1'b1, `BLX_OFF_FILE_ADDR, 32'h00);
    xfer(1'b1, `BLX_OFF_FILE_DATA, 32'h55);
    xfer(1'b1, `BLX_OFF_ACC, 32'h55);
    run(14'h0500);
    run(14'h0180);
    rc(`BLX_OFF_FILE_DATA, 32'hff, 32'h00);
    xfer(1'b1, `BLX_OFF_FILE_DATA, 32'h55);
    run(14'h0500);
    rc(`BLX_OFF_STATUS, 32'h1, 32'h0);
    run(14'h017f);
    rc(`BLX_OFF_ACC, 32'hff, 32'h00);
    rc(`BLX_OFF_STATUS, 32'h1, 32'h1);
  endtask
  task automatic t_kick();
    run(14'h0064);
    // Freeze for 20 edges: a running prescaler would pass 16 and show in the masked bits.
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
    rc(`BLX_OFF_WATCHDOG, 32'hf0ff, 32'h0);
    rc(`BLX_OFF_STATUS, 32'h6, 32'h6);
  endtask
  // Unmapped read and a write that lands while a call is still running.
  task automatic t_refuse();
    xfer(1'b0, 8'h24, 32'h0);
    ec(1'b1);
    xfer(1'b1, `BLX_OFF_INSTR, 32'h2000);
    xfer(1'b1, `BLX_OFF_ACC, 32'h99);
    ec(1'b1);
    do @(posedge pclk); while (exec_busy !== 1'b0);
    @(posedge pclk);
    rc(`BLX_OFF_ACC, 32'hff, 32'h00);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    req = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_and();
    t_bits();
    t_skip();
    t_call();
    t_clear();
    t_kick();
    t_refuse();
    print_verdict();
  end
endmodule // tb
